// file: core/data_address_pointer_regs_consts.vh
// constants for the data-address pointer register set
`ifndef DATA_ADDRESS_POINTER_REGS_CONSTS_VH
`define DATA_ADDRESS_POINTER_REGS_CONSTS_VH

// memory-mapped register offsets (word index on the mmr port)
`define MMR_CIRC_BASE_PAIR0 5'h00
`define MMR_CIRC_BASE_PAIR1 5'h01
`define MMR_CIRC_BASE_PAIR2 5'h02
`define MMR_CIRC_BASE_PAIR3 5'h03
`define MMR_CIRC_BASE_COEF  5'h04
`define MMR_CIRC_LEN_LOW    5'h05
`define MMR_CIRC_LEN_HIGH   5'h06
`define MMR_CIRC_LEN_COEF   5'h07
`define MMR_PAGE_OFFSET     5'h08
`define MMR_PAGE_HIGH       5'h09
`define MMR_IO_PAGE         5'h0a
`define MMR_STACK_PAGE_HIGH 5'h0b
`define MMR_DATA_STACK_LOW  5'h0c
`define MMR_SYS_STACK_LOW   5'h0d

// field widths and positions
`define PAGE_W     7
`define WORD_W     16
`define ADDR_W     23
`define IO_PAGE_W  9
`define IO_PAGE_HI 8
`define IO_OFF_W   7

// reset values
`define RST_WORD   16'h0000
`define RST_PAGE   7'h00
`define RST_IOPAGE 9'h000

// stack operation codes
`define STK_NONE   3'h0
`define STK_CALL   3'h1
`define STK_PUSH   3'h2
`define STK_RET    3'h3
`define STK_POP    3'h4

// pointer selectors: 0..7 auxiliary, 8 coefficient
`define PSEL_COEF  4'h8

`endif

// file: core/data_address_pointer_regs.v
// data-address pointer registers: circular base/length, page, io page, stacks
//
// What this block does
// - five 16-bit circular start-address registers, any alignment allowed.
// - start address added only when pointer is configured circular.
// - base pairs 0-1,2-3,4-5,6-7 and a coefficient base.
// - circular address is high page joined with low part plus base.
// - three 16-bit length registers holding word counts up to 65535.
// - low length for pointers 0-3, high for 4-7, coef length separate.
// - legacy mode uses the low length for all eight pointers.
// - extended page pointer is 7-bit high joined to 16-bit offset.
// - direct mode uses extended pointer; absolute joins page high and immediate.
// - extended page pointer by instruction only; halves also memory mapped.
// - 9-bit io page selects one 128-word page of io space.
// - io page lives in bits 8-0; bits 15-9 ignored.
// - extended data stack pointer is stack page joined to data stack low.
// - extended system stack pointer is stack page joined to system low.
// - extended stack pointers by instruction only; lows also memory mapped.
// - stack page high is memory mapped; extended stack writes update it.
// - calls predecrement both stack pointers before pushing.
// - push predecrements only the data stack pointer.
// - returns pop the pair then increment both pointers.
// - pop increments only the data stack pointer after reading.
// - stack steps wrap in 16 bits, never touching the page.
// - each pointer has a 7-bit page part and 16-bit low part.
`timescale 1ns/10ps
`include "data_address_pointer_regs_consts.vh"

module data_address_pointer_regs (
    // clock and reset
    input  wire                   clk_in,
    input  wire                   reset_in,
    // memory-mapped register port
    input  wire                   mmr_wr_in,
    input  wire                   mmr_rd_in,
    input  wire [4:0]             mmr_addr_in,
    input  wire [15:0]            mmr_wdata_in,
    output reg  [15:0]            mmr_rdata_out,
    // dedicated-instruction writes of extended pointers
    input  wire                   ext_page_wr_in,
    input  wire [22:0]            ext_page_wdata_in,
    input  wire                   ext_dsp_wr_in,
    input  wire [22:0]            ext_dsp_wdata_in,
    input  wire                   ext_ssp_wr_in,
    input  wire [22:0]            ext_ssp_wdata_in,
    // stack operation request
    input  wire [2:0]             stack_op_in,
    // circular address request
    input  wire [3:0]             ptr_sel_in,
    input  wire [22:0]            ptr_ext_in,
    input  wire [8:0]             pointer_config_status_in,
    input  wire                   legacy_compat_mode_in,
    input  wire [1:0]             ptr_step_in,
    // direct addressing request
    input  wire [15:0]            abs_imm_in,
    input  wire [6:0]             io_offset_in,
    // generated addresses
    output reg  [22:0]            circ_addr_out,
    output reg  [15:0]            ptr_next_low_out,
    output reg  [22:0]            ext_page_pointer_out,
    output reg  [22:0]            abs_addr_out,
    output reg  [15:0]            io_addr_out,
    output reg  [22:0]            ext_data_stack_ptr_out,
    output reg  [22:0]            ext_system_stack_ptr_out,
    output reg  [22:0]            data_push_addr_out,
    output reg  [22:0]            sys_push_addr_out
);

// ----------------------------------------------------------------
// register storage
// ----------------------------------------------------------------
reg  [15:0] circ_base_ff [0:4];
reg  [15:0] circ_len_ff  [0:2];
reg  [15:0] page_offset_reg_ff;
reg  [6:0]  page_high_reg_ff;
reg  [8:0]  io_page_select_ff;
reg  [6:0]  stack_page_high_ff;
reg  [15:0] data_stack_ptr_low_ff;
reg  [15:0] system_stack_ptr_low_ff;

reg  [15:0] nxt_dsp;
reg  [15:0] nxt_ssp;
reg  [6:0]  nxt_sph;
reg  [15:0] nxt_rdata;

// ----------------------------------------------------------------
// circular base and length registers
// ----------------------------------------------------------------
genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_base
        always @(posedge clk_in) begin
            if (reset_in) begin
                circ_base_ff[gi] <= `RST_WORD;
            end else if (mmr_wr_in && mmr_addr_in == `MMR_CIRC_BASE_PAIR0 + gi) begin
                circ_base_ff[gi] <= mmr_wdata_in;
            end
        end
    end
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_len
        always @(posedge clk_in) begin
            if (reset_in) begin
                circ_len_ff[gi] <= `RST_WORD;
            end else if (mmr_wr_in && mmr_addr_in == `MMR_CIRC_LEN_LOW + gi) begin
                circ_len_ff[gi] <= mmr_wdata_in;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// page, io page and stack registers
// ----------------------------------------------------------------
always @(posedge clk_in) begin
    if (reset_in) begin
        page_offset_reg_ff <= `RST_WORD;
        page_high_reg_ff   <= `RST_PAGE;
        io_page_select_ff  <= `RST_IOPAGE;
    end else begin
        if (ext_page_wr_in) begin
            page_high_reg_ff   <= ext_page_wdata_in[22:16];
            page_offset_reg_ff <= ext_page_wdata_in[15:0];
        end else if (mmr_wr_in) begin
            if (mmr_addr_in == `MMR_PAGE_OFFSET)
                page_offset_reg_ff <= mmr_wdata_in;
            if (mmr_addr_in == `MMR_PAGE_HIGH)
                page_high_reg_ff <= mmr_wdata_in[`PAGE_W-1:0];
        end
        if (mmr_wr_in && mmr_addr_in == `MMR_IO_PAGE)
            io_page_select_ff <= mmr_wdata_in[`IO_PAGE_HI:0];
    end
end

// stack pointer next state; an extended write wins over a step
always @* begin
    nxt_dsp = data_stack_ptr_low_ff;
    nxt_ssp = system_stack_ptr_low_ff;
    nxt_sph = stack_page_high_ff;
    case (stack_op_in)
        `STK_CALL: begin
            nxt_dsp = data_stack_ptr_low_ff - 16'h0001;
            nxt_ssp = system_stack_ptr_low_ff - 16'h0001;
        end
        `STK_PUSH: begin
            nxt_dsp = data_stack_ptr_low_ff - 16'h0001;
        end
        `STK_RET: begin
            nxt_dsp = data_stack_ptr_low_ff + 16'h0001;
            nxt_ssp = system_stack_ptr_low_ff + 16'h0001;
        end
        `STK_POP: begin
            nxt_dsp = data_stack_ptr_low_ff + 16'h0001;
        end
        default: begin
            nxt_dsp = data_stack_ptr_low_ff;
        end
    endcase
    if (mmr_wr_in && mmr_addr_in == `MMR_DATA_STACK_LOW)
        nxt_dsp = mmr_wdata_in;
    if (mmr_wr_in && mmr_addr_in == `MMR_SYS_STACK_LOW)
        nxt_ssp = mmr_wdata_in;
    if (mmr_wr_in && mmr_addr_in == `MMR_STACK_PAGE_HIGH)
        nxt_sph = mmr_wdata_in[`PAGE_W-1:0];
    if (ext_dsp_wr_in) begin
        nxt_dsp = ext_dsp_wdata_in[15:0];
        nxt_sph = ext_dsp_wdata_in[22:16];
    end
    if (ext_ssp_wr_in) begin
        nxt_ssp = ext_ssp_wdata_in[15:0];
        nxt_sph = ext_ssp_wdata_in[22:16];
    end
end

always @(posedge clk_in) begin
    if (reset_in) begin
        data_stack_ptr_low_ff   <= `RST_WORD;
        system_stack_ptr_low_ff <= `RST_WORD;
        stack_page_high_ff      <= `RST_PAGE;
    end else begin
        data_stack_ptr_low_ff   <= nxt_dsp;
        system_stack_ptr_low_ff <= nxt_ssp;
        stack_page_high_ff      <= nxt_sph;
    end
end

// ----------------------------------------------------------------
// circular address generation
// ----------------------------------------------------------------
reg  [15:0] sel_base;
reg  [15:0] sel_len;
reg         sel_circ;
reg  [15:0] low_part;
reg  [15:0] stepped;
reg  [22:0] nxt_circ_addr;

always @*
begin
    low_part = ptr_ext_in[15:0];
    if (ptr_sel_in == `PSEL_COEF)
        sel_base = circ_base_ff[4];
    else
        sel_base = circ_base_ff[ptr_sel_in[2:1]];
    if (ptr_sel_in == `PSEL_COEF)
        sel_len = circ_len_ff[2];
    else if (legacy_compat_mode_in || !ptr_sel_in[2])
        sel_len = circ_len_ff[0];
    else
        sel_len = circ_len_ff[1];
    sel_circ = (ptr_sel_in <= `PSEL_COEF) && pointer_config_status_in[ptr_sel_in];
    if (sel_circ)
        nxt_circ_addr = {ptr_ext_in[22:16], low_part + sel_base};
    else
        nxt_circ_addr = ptr_ext_in;
    // index wrap; step 1 is +1, 2 is -1
    stepped = low_part;
    if (ptr_step_in == 2'h1) begin
        if (sel_circ && (sel_len == `RST_WORD || low_part >= sel_len - 16'h0001))
            stepped = `RST_WORD;
        else
            stepped = low_part + 16'h0001;
    end else if (ptr_step_in == 2'h2) begin
        if (sel_circ && low_part == `RST_WORD)
            stepped = (sel_len == `RST_WORD) ? `RST_WORD : sel_len - 16'h0001;
        else
            stepped = low_part - 16'h0001;
    end
end

// ----------------------------------------------------------------
// read mux; reserved io-page bits read as zero
// ----------------------------------------------------------------
always @* begin
    case (mmr_addr_in)
        `MMR_CIRC_BASE_PAIR0: nxt_rdata = circ_base_ff[0];
        `MMR_CIRC_BASE_PAIR1: nxt_rdata = circ_base_ff[1];
        `MMR_CIRC_BASE_PAIR2: nxt_rdata = circ_base_ff[2];
        `MMR_CIRC_BASE_PAIR3: nxt_rdata = circ_base_ff[3];
        `MMR_CIRC_BASE_COEF:  nxt_rdata = circ_base_ff[4];
        `MMR_CIRC_LEN_LOW:    nxt_rdata = circ_len_ff[0];
        `MMR_CIRC_LEN_HIGH:   nxt_rdata = circ_len_ff[1];
        `MMR_CIRC_LEN_COEF:   nxt_rdata = circ_len_ff[2];
        `MMR_PAGE_OFFSET:     nxt_rdata = page_offset_reg_ff;
        `MMR_PAGE_HIGH:       nxt_rdata = {9'h000, page_high_reg_ff};
        `MMR_IO_PAGE:         nxt_rdata = {7'h00, io_page_select_ff};
        `MMR_STACK_PAGE_HIGH: nxt_rdata = {9'h000, stack_page_high_ff};
        `MMR_DATA_STACK_LOW:  nxt_rdata = data_stack_ptr_low_ff;
        `MMR_SYS_STACK_LOW:   nxt_rdata = system_stack_ptr_low_ff;
        default:              nxt_rdata = `RST_WORD;
    endcase
end

// ----------------------------------------------------------------
// registered outputs; one cycle behind the request
// ----------------------------------------------------------------
always @(posedge clk_in) begin
    if (reset_in) begin
        mmr_rdata_out            <= `RST_WORD;
        circ_addr_out            <= 23'h000000;
        ptr_next_low_out         <= `RST_WORD;
        ext_page_pointer_out     <= 23'h000000;
        abs_addr_out             <= 23'h000000;
        io_addr_out              <= `RST_WORD;
        ext_data_stack_ptr_out   <= 23'h000000;
        ext_system_stack_ptr_out <= 23'h000000;
        data_push_addr_out       <= 23'h000000;
        sys_push_addr_out        <= 23'h000000;
    end else begin
        if (mmr_rd_in)
            mmr_rdata_out <= nxt_rdata;
        circ_addr_out    <= nxt_circ_addr;
        ptr_next_low_out <= stepped;
        ext_page_pointer_out <= {nxt_page_high(page_high_reg_ff), page_offset_reg_ff};
        abs_addr_out <= {page_high_reg_ff, abs_imm_in};
        io_addr_out <= {io_page_select_ff, io_offset_in};
        ext_data_stack_ptr_out <= {stack_page_high_ff, data_stack_ptr_low_ff};
        ext_system_stack_ptr_out <= {stack_page_high_ff, system_stack_ptr_low_ff};
        // extended values only by port
        // page follows a same-cycle extended write, so the push address matches the new pointer
        data_push_addr_out <= {nxt_sph, nxt_dsp};
        sys_push_addr_out  <= {nxt_sph, nxt_ssp};
    end
end

// identity helper keeps the page field width explicit
function [6:0] nxt_page_high;
    input [6:0] p;
    begin
        nxt_page_high = p;
    end
endfunction

endmodule // data_address_pointer_regs

// file: tb/data_address_pointer_regs_chk.sv
// checker: port-level assertions for the pointer register block
`timescale 1ns/10ps
`include "data_address_pointer_regs_consts.vh"
module data_address_pointer_regs_chk (
    input wire        clk_in, reset_in, mmr_wr_in, mmr_rd_in,
    input wire        ext_dsp_wr_in, ext_ssp_wr_in, legacy_compat_mode_in,
    input wire [4:0]  mmr_addr_in,
    input wire [2:0]  stack_op_in,
    input wire [3:0]  ptr_sel_in,
    input wire [8:0]  pointer_config_status_in,
    input wire [6:0]  io_offset_in,
    input wire [15:0] abs_imm_in, mmr_rdata_out, io_addr_out,
    input wire [22:0] ptr_ext_in, circ_addr_out, abs_addr_out, ext_page_pointer_out,
    input wire [22:0] ext_data_stack_ptr_out, ext_system_stack_ptr_out,
    input wire [22:0] data_push_addr_out, sys_push_addr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // a stack-register or extended stack write may override a stack step, so steps are judged only on quiet cycles
    wire quiet = !mmr_wr_in && !ext_dsp_wr_in && !ext_ssp_wr_in;
    wire circ  = (ptr_sel_in <= 4'h8) && pointer_config_status_in[ptr_sel_in];
    wire io_wr = mmr_wr_in && (mmr_addr_in == `MMR_IO_PAGE);
    wire [15:0] d_step = (stack_op_in == `STK_CALL || stack_op_in == `STK_PUSH) ? 16'hffff :
                         (stack_op_in == `STK_RET || stack_op_in == `STK_POP) ? 16'h0001 : 16'h0000;
    wire [15:0] s_step = (stack_op_in == `STK_CALL) ? 16'hffff :
                         (stack_op_in == `STK_RET) ? 16'h0001 : 16'h0000;
    AST_ABS_IMM: assert property (1'b1 |=> abs_addr_out[15:0] == $past(abs_imm_in))
        else $error("absolute address low half wrong");
    AST_PAGE_SHARE: assert property (abs_addr_out[22:16] == ext_page_pointer_out[22:16])
        else $error("absolute and page pointer pages differ");
    AST_IO_OFF: assert property (1'b1 |=> io_addr_out[6:0] == $past(io_offset_in))
        else $error("io offset not passed");
    AST_IO_HI: assert property ($changed(io_addr_out[15:7]) |-> $past(io_wr) || $past(io_wr, 2))
        else $error("io page changed without a write");
    AST_RD_IO: assert property (mmr_rd_in && mmr_addr_in == `MMR_IO_PAGE |=> mmr_rdata_out[15:9] == 7'h00)
        else $error("io page upper bits not zero");
    AST_RD_UNMAP: assert property (mmr_rd_in && mmr_addr_in > `MMR_SYS_STACK_LOW |=> mmr_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    AST_NONCIRC: assert property (!circ |=> circ_addr_out == $past(ptr_ext_in))
        else $error("base added outside circular mode");
    AST_CIRC_PAGE: assert property (circ |=> circ_addr_out[22:16] == $past(ptr_ext_in[22:16]))
        else $error("circular page not from pointer");
    AST_STK_DATA: assert property (quiet |=> data_push_addr_out[15:0] == ext_data_stack_ptr_out[15:0] + $past(d_step))
        else $error("data stack step wrong");
    AST_STK_SYS: assert property (quiet |=> sys_push_addr_out[15:0] == ext_system_stack_ptr_out[15:0] + $past(s_step))
        else $error("system stack step wrong");
    AST_STK_PAGE: assert property (quiet |=> data_push_addr_out[22:16] == ext_data_stack_ptr_out[22:16])
        else $error("stack step touched page");
    AST_STK_SHARE: assert property (ext_data_stack_ptr_out[22:16] == ext_system_stack_ptr_out[22:16])
        else $error("stack pointers on different pages");
    cover property (quiet && stack_op_in == `STK_CALL);
    cover property (circ && legacy_compat_mode_in);
    cover property (mmr_rd_in && mmr_addr_in > `MMR_SYS_STACK_LOW);
endmodule // data_address_pointer_regs_chk

// file: tb/cpu_request_model.sv
// cpu-side model: decode and address-unit requests cut from a random word
`timescale 1ns/10ps
module cpu_request_model (
    input  wire [63:0] rnd_in,
    output wire [3:0]  ptr_sel_out,
    output wire [22:0] ptr_ext_out,
    output wire [8:0]  cfg_out,
    output wire        legacy_out,
    output wire [1:0]  step_out,
    output wire [15:0] abs_imm_out,
    output wire [6:0]  io_off_out
);
    // selectors stay in 0..9; half the indexes are small so short buffers wrap often
    assign ptr_sel_out = (rnd_in[3:0] > 4'h9) ? rnd_in[3:0] - 4'h6 : rnd_in[3:0];
    assign ptr_ext_out = {rnd_in[26:20], rnd_in[63] ? {11'h000, rnd_in[8:4]} : rnd_in[19:4]};
    assign cfg_out     = rnd_in[35:27];
    assign legacy_out  = rnd_in[36];
    assign step_out    = rnd_in[38:37];
    assign abs_imm_out = rnd_in[54:39];
    assign io_off_out  = rnd_in[61:55];
endmodule // cpu_request_model

// file: tb/tb_data_address_pointer_regs.sv
// testbench for the data-address pointer register block
`timescale 1ns/10ps
`include "data_address_pointer_regs_consts.vh"
module tb_data_address_pointer_regs;
    reg         clk_in, reset_in, mmr_wr_in, mmr_rd_in;
    reg         ext_page_wr_in, ext_dsp_wr_in, ext_ssp_wr_in;
    reg  [4:0]  mmr_addr_in;
    reg  [15:0] mmr_wdata_in;
    reg  [22:0] ext_page_wdata_in, ext_dsp_wdata_in, ext_ssp_wdata_in;
    reg  [2:0]  stack_op_in;
    reg  [63:0] rnd;
    wire [3:0]  ptr_sel_in;
    wire [8:0]  pointer_config_status_in;
    wire        legacy_compat_mode_in;
    wire [1:0]  ptr_step_in;
    wire [6:0]  io_offset_in;
    wire [15:0] abs_imm_in, mmr_rdata_out, ptr_next_low_out, io_addr_out;
    wire [22:0] ptr_ext_in, circ_addr_out, ext_page_pointer_out, abs_addr_out;
    wire [22:0] ext_data_stack_ptr_out, ext_system_stack_ptr_out;
    wire [22:0] data_push_addr_out, sys_push_addr_out;
    reg  [15:0] sh [0:13];
    reg  [15:0] dl, sl;
    reg  [38:0] e;
    reg  [2:0]  op;
    integer     error_cnt, checked, cyc, i;

    data_address_pointer_regs uut (.*);
    cpu_request_model cpu (.rnd_in(rnd), .ptr_sel_out(ptr_sel_in), .ptr_ext_out(ptr_ext_in),
        .cfg_out(pointer_config_status_in), .legacy_out(legacy_compat_mode_in),
        .step_out(ptr_step_in), .abs_imm_out(abs_imm_in), .io_off_out(io_offset_in));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task check(input [22:0] got, input [22:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // strobes stay up between back-to-back accesses; callers lower them
    task acc(input wr, input [4:0] a, input [15:0] d);
        begin
            mmr_wr_in = wr;
            mmr_rd_in = !wr;
            mmr_addr_in = a;
            mmr_wdata_in = d;
            @(negedge clk_in);
        end
    endtask

    function [15:0] msk(input [4:0] a);
        msk = (a == 5'h09 || a == 5'h0b) ? 16'h007f : (a == 5'h0a) ? 16'h01ff :
              (a > 5'h0d) ? 16'h0000 : 16'hffff;
    endfunction

    task rd_all(input written);
        begin
            for (i = 0; i < 15; i = i + 1) begin
                acc(1'b0, (i == 14) ? 5'h1f : i[4:0], 16'h0000);
                check({7'h00, mmr_rdata_out}, (written && i < 14) ? {7'h00, sh[i] & msk(i[4:0])} : 23'h0);
            end
            mmr_rd_in = 1'b0;
        end
    endtask

    // expected {next index, address}; a length of zero never wraps past zero
    function [38:0] exp_circ(input [3:0] s, input [22:0] p, input [8:0] c, input lg, input [1:0] st);
        reg [15:0] b, l, n;
        reg        on;
        begin
            on = (s <= 4'h8) && c[s];
            b = (s == 4'h8) ? sh[4] : sh[s[2:1]];
            l = (s == 4'h8) ? sh[7] : (lg || s < 4'h4) ? sh[5] : sh[6];
            n = p[15:0];
            if (st == 2'h1)
                n = (on && (l == 16'h0 || n >= l - 16'h1)) ? 16'h0 : n + 16'h1;
            if (st == 2'h2)
                n = (on && n == 16'h0) ? ((l == 16'h0) ? 16'h0 : l - 16'h1) : n - 16'h1;
            exp_circ = {n, on ? {p[22:16], p[15:0] + b} : p};
        end
    endfunction

    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // the whole run needs about 400 cycles
    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end

    initial begin
        {reset_in, mmr_wr_in, mmr_rd_in, ext_page_wr_in, ext_dsp_wr_in, ext_ssp_wr_in} = 6'h20;
        {mmr_addr_in, mmr_wdata_in, stack_op_in} = 24'h0;
        {ext_page_wdata_in, ext_dsp_wdata_in, ext_ssp_wdata_in} = 69'h0;
        {error_cnt, checked, cyc} = 96'h0;
        rnd = {32'h0, $urandom(87)};
        repeat (20) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 1'b0;
        rd_all(1'b0);
        // lengths 5 and 0 force both wrap corners
        for (i = 0; i < 14; i = i + 1) begin
            sh[i] = (i == 5) ? 16'h0005 : (i == 7) ? 16'h0000 : $urandom;
            acc(1'b1, i[4:0], sh[i]);
        end
        mmr_wr_in = 1'b0;
        rd_all(1'b1);
        ext_page_wr_in = 1'b1;
        ext_page_wdata_in = $urandom;
        @(negedge clk_in);
        ext_page_wr_in = 1'b0;
        sh[8] = ext_page_wdata_in[15:0];
        sh[9] = {9'h000, ext_page_wdata_in[22:16]};
        for (i = 0; i < 300; i = i + 1) begin
            rnd = {$urandom, $urandom};
            @(negedge clk_in);
            e = exp_circ(ptr_sel_in, ptr_ext_in, pointer_config_status_in, legacy_compat_mode_in, ptr_step_in);
            check(circ_addr_out, e[22:0]);
            check({7'h00, ptr_next_low_out}, {7'h00, e[38:23]});
            check(abs_addr_out, {sh[9][6:0], abs_imm_in});
            check(ext_page_pointer_out, {sh[9][6:0], sh[8]});
            check({7'h00, io_addr_out}, {7'h00, sh[10][8:0], io_offset_in});
        end
        {ext_dsp_wr_in, ext_ssp_wr_in} = 2'h3;
        ext_dsp_wdata_in = {7'h2a, 16'h0000};
        ext_ssp_wdata_in = {7'h2a, 16'h0001};
        @(negedge clk_in);
        {ext_dsp_wr_in, ext_ssp_wr_in} = 2'h0;
        {dl, sl} = {16'h0000, 16'h0001};
        check(data_push_addr_out, {7'h2a, dl});
        // back-to-back steps crossing 0000/ffff both ways
        for (i = 0; i < 6; i = i + 1) begin
            op = {`STK_PUSH, `STK_CALL, `STK_CALL, `STK_RET, `STK_POP, `STK_RET} >> (15 - 3 * i);
            stack_op_in = op;
            @(negedge clk_in);
            dl = (op == `STK_CALL || op == `STK_PUSH) ? dl - 16'h1 : (op == `STK_NONE) ? dl : dl + 16'h1;
            sl = (op == `STK_CALL) ? sl - 16'h1 : (op == `STK_RET) ? sl + 16'h1 : sl;
            check(data_push_addr_out, {7'h2a, dl});
            check(sys_push_addr_out, {7'h2a, sl});
        end
        stack_op_in = `STK_NONE;
        @(negedge clk_in);
        check(ext_data_stack_ptr_out, {7'h2a, dl});
        check(ext_system_stack_ptr_out, {7'h2a, sl});
        acc(1'b0, `MMR_STACK_PAGE_HIGH, 16'h0000);
        check({7'h00, mmr_rdata_out}, 23'h00002a);
        acc(1'b0, `MMR_DATA_STACK_LOW, 16'h0000);
        check({7'h00, mmr_rdata_out}, {7'h00, dl});
        mmr_rd_in = 1'b0;
        tally_and_finish;
    end
endmodule // tb_data_address_pointer_regs

bind data_address_pointer_regs data_address_pointer_regs_chk chk (.*);
